// ==== hw/tlms_core.sv ====
// trap depth, execution mode, address masking and interrupt gating for one virtual cpu
// What this block does
// RQ1: faulting masked access records zero-upper fault address
// RQ2: branch target into next counter keeps upper bits
// RQ3: next counter plus four keeps upper bits
// RQ4: saved counter register access keeps upper bits
// RQ5: mask set zeroes upper fetch bits immediately
// RQ6: trap return with mask may zero upper
// RQ7: supervisor flag selects privileged or nonprivileged
// RQ8: hypervisor flag forces hyperprivileged mode
// RQ9: privileged-bound disrupt traps only when enabled
// RQ10: hyper-bound disrupt traps outside hyper or enabled
// RQ11: trap depth zero means no trap
// RQ12: maximum six, supervisor maximum two
// RQ13: power-on reset loads maximum trap depth
// RQ14: user write faults, hyper write saturates
// RQ15: supervisor write of three up stores two
// RQ16: depth write touches no other state
// RQ17: only low three data bits stored
// RQ18: software avoids undefined depth and mode combos
// RQ19: interrupt accepted only above threshold
// RQ20: higher interrupt level means higher priority
// RQ21: level fifteen is maskable like others
// RQ22: masked virtual addresses clear upper bits
// RQ23: trap entry increments, return restores depth
// RQ24: four-bit threshold via state register ops
`timescale 1ns/1ns
module tlms_core
(
    input  wire logic        core_clk,          // core clock
    input  wire logic        sys_rst,           // power-on reset, active high
    input  wire logic        supervisor_flag,   // supervisor flag
    input  wire logic        hypervisor_flag,   // hypervisor flag
    input  wire logic        address_mask_bit,  // current address mask bit
    input  wire logic        interrupt_enable_bit, // interrupt enable
    input  wire logic        mask_write,        // status write setting mask bit this cycle
    input  wire logic        mask_write_val,    // new mask bit value
    input  wire logic        state_reg_write_op, // privileged register write strobe
    input  wire logic        state_reg_read_op, // privileged register read strobe
    input  wire logic [4:0]  state_reg_sel,     // privileged register number
    input  wire logic [63:0] state_reg_wdata,   // write data
    input  wire logic        retire,            // instruction retires, counters advance
    input  wire logic        taken_transfer,    // retiring instruction is a taken transfer
    input  wire logic [63:0] transfer_target,   // transfer target address
    input  wire logic        trap_entry,        // trap is entered
    input  wire logic        trap_return,       // trap return
    input  wire logic [2:0]  saved_depth,       // depth restored on return
    input  wire logic        saved_mask,        // mask bit from saved trap status
    input  wire logic [63:0] saved_counter,     // trap saved counter value
    input  wire logic [63:0] saved_next_counter, // trap saved next counter value
    input  wire logic        access_fault,      // memory access faulted
    input  wire logic [63:0] access_addr,       // faulting virtual address
    input  wire logic [63:0] virt_addr,         // virtual address to send out
    input  wire logic        priv_disrupt,      // pending disrupt aimed at privileged
    input  wire logic        hyper_disrupt,     // pending disrupt aimed at hyper
    input  wire logic        irq_valid,         // leveled interrupt pending
    input  wire logic [3:0]  irq_level,         // its level
    output logic [2:0]  trap_depth,             // trap depth register
    output logic [3:0]  interrupt_threshold,    // threshold register
    output logic [2:0]  exec_mode,              // one-hot execution mode
    output logic        in_trap,                // trap depth nonzero
    output logic        priv_opcode_fault,      // privileged opcode exception pulse
    output logic [63:0] state_reg_rdata,        // read data
    output logic [63:0] program_counter,        // program counter
    output logic [63:0] next_fetch_counter,     // next fetch counter
    output logic [63:0] data_fault_addr_reg,    // data fault address
    output logic [63:0] masked_vaddr,           // virtual address after masking
    output logic        priv_disrupt_take,      // privileged-bound disrupt traps
    output logic        hyper_disrupt_take,     // hyper-bound disrupt traps
    output logic        irq_take,               // leveled interrupt accepted
    output logic [3:0]  irq_take_level          // accepted level
);
    tlms_pkg::tlms_mode_t mode_nxt;
    tlms_pkg::tlms_mode_t mode_r;
    logic [2:0]  depth_r;
    logic [2:0]  depth_nxt;
    logic [3:0]  thresh_r;
    logic [63:0] prog_cnt_r;
    logic [63:0] next_cnt_r;
    logic [63:0] next_cnt_nxt;
    logic [63:0] prog_cnt_nxt;
    logic [2:0]  wr_val;
    logic [2:0]  wr_sat;
    logic        wr_depth;
    logic        wr_thresh;
    logic        rd_ok;
    logic        mask_rise;
    logic        ret_mask;
    logic        irq_ok;
    logic [63:0] rdata_nxt;

    // mode decode
    assign mode_nxt = hypervisor_flag ? tlms_pkg::TLMS_HYPER :                   // RQ8
                      supervisor_flag ? tlms_pkg::TLMS_SUPV : tlms_pkg::TLMS_USER; // RQ7

    assign wr_depth  = state_reg_write_op && (state_reg_sel == tlms_pkg::REG_TRAP_DEPTH)
                       && (mode_nxt != tlms_pkg::TLMS_USER);
    assign wr_thresh = state_reg_write_op && (state_reg_sel == tlms_pkg::REG_THRESHOLD)
                       && (mode_nxt != tlms_pkg::TLMS_USER); // RQ24
    assign rd_ok     = state_reg_read_op && (mode_nxt != tlms_pkg::TLMS_USER);
    assign wr_val    = state_reg_wdata[2:0]; // RQ17

    // saturation depends on privilege
    assign wr_sat = (mode_nxt == tlms_pkg::TLMS_HYPER)
                    ? ((wr_val > tlms_pkg::TOP_TRAP_DEPTH) ? tlms_pkg::TOP_TRAP_DEPTH : wr_val) // RQ14
                    : ((wr_val > tlms_pkg::TOP_SUPV_DEPTH) ? tlms_pkg::TOP_SUPV_DEPTH : wr_val); // RQ15

    // depth write alters depth only; entry increments, return restores
    assign depth_nxt = wr_depth ? wr_sat :                            // RQ16
                       trap_entry ? ((depth_r == tlms_pkg::TOP_TRAP_DEPTH) ? depth_r
                                     : 3'(depth_r + tlms_pkg::DEPTH_ONE)) : // RQ23
                       trap_return ? saved_depth : depth_r;           // RQ23

    assign mask_rise = mask_write && mask_write_val && !address_mask_bit;
    assign ret_mask  = saved_mask && tlms_pkg::RETURN_MASKS; // RQ6

    // fetch counters: transfers and increments keep upper bits
    always_comb
    begin
        prog_cnt_nxt = prog_cnt_r;
        next_cnt_nxt = next_cnt_r;
        if (trap_return)
        begin
            prog_cnt_nxt = ret_mask ? {tlms_pkg::ZERO_HALF, saved_counter[31:0]}
                                    : saved_counter; // RQ6
            next_cnt_nxt = ret_mask ? {tlms_pkg::ZERO_HALF, saved_next_counter[31:0]}
                                    : saved_next_counter; // RQ6
        end
        else if (mask_rise)
        begin
            next_cnt_nxt = {tlms_pkg::ZERO_HALF, next_cnt_r[31:0]}; // RQ5
        end
        else if (retire)
        begin
            prog_cnt_nxt = next_cnt_r;
            next_cnt_nxt = taken_transfer ? transfer_target              // RQ2
                                          : 64'(next_cnt_r + tlms_pkg::FETCH_STEP); // RQ3
        end
    end

    // saved counters are read without masking
    assign rdata_nxt = (state_reg_sel == tlms_pkg::REG_TRAP_DEPTH) ? {61'h0, depth_r} :
                       (state_reg_sel == tlms_pkg::REG_THRESHOLD) ? {60'h0, thresh_r} :
                       (state_reg_sel == tlms_pkg::REG_SAVED_CNT) ? saved_counter :  // RQ4
                       (state_reg_sel == tlms_pkg::REG_SAVED_NEXT) ? saved_next_counter
                                                                   : 64'h0; // RQ4

    // level compare treats fifteen like any level
    assign irq_ok = irq_valid && (irq_level > thresh_r); // RQ19 RQ21

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            depth_r <= tlms_pkg::TOP_TRAP_DEPTH; // RQ13
            thresh_r <= tlms_pkg::THRESH_RST;
            mode_r <= tlms_pkg::TLMS_USER;
            prog_cnt_r <= 64'h0;
            next_cnt_r <= tlms_pkg::FETCH_STEP;
        end
        else
        begin
            depth_r <= depth_nxt;
            if (wr_thresh)
                thresh_r <= state_reg_wdata[3:0]; // RQ24
            mode_r <= mode_nxt;
            prog_cnt_r <= prog_cnt_nxt;
            next_cnt_r <= next_cnt_nxt;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            priv_opcode_fault <= 1'b0;
            state_reg_rdata <= 64'h0;
            data_fault_addr_reg <= 64'h0;
            masked_vaddr <= 64'h0;
            priv_disrupt_take <= 1'b0;
            hyper_disrupt_take <= 1'b0;
            irq_take <= 1'b0;
            irq_take_level <= 4'h0;
            in_trap <= 1'b1;
        end
        else
        begin
            priv_opcode_fault <= state_reg_write_op && (mode_nxt == tlms_pkg::TLMS_USER); // RQ14
            if (rd_ok)
                state_reg_rdata <= rdata_nxt;
            if (access_fault)
                data_fault_addr_reg <= address_mask_bit
                    ? {tlms_pkg::ZERO_HALF, access_addr[31:0]} : access_addr; // RQ1
            masked_vaddr <= address_mask_bit
                ? {tlms_pkg::ZERO_HALF, virt_addr[31:0]} : virt_addr; // RQ22
            priv_disrupt_take <= priv_disrupt && interrupt_enable_bit
                                 && (mode_nxt != tlms_pkg::TLMS_HYPER); // RQ9
            hyper_disrupt_take <= hyper_disrupt && ((mode_nxt != tlms_pkg::TLMS_HYPER)
                                  || interrupt_enable_bit); // RQ10
            irq_take <= irq_ok; // RQ19
            irq_take_level <= irq_ok ? irq_level : 4'h0; // RQ20
            in_trap <= (depth_nxt != tlms_pkg::DEPTH_ZERO); // RQ11
        end
    end

    assign trap_depth          = depth_r;
    assign interrupt_threshold = thresh_r;
    assign exec_mode           = mode_r;
    assign program_counter     = prog_cnt_r;
    assign next_fetch_counter  = next_cnt_r;

    chk_reset_depth: assert property (@(posedge core_clk)
        $fell(sys_rst) |-> depth_r == tlms_pkg::TOP_TRAP_DEPTH) else $error("depth not max"); // RQ13
    chk_supv_sat: assert property (@(posedge core_clk) disable iff (sys_rst)
        wr_depth && mode_nxt == tlms_pkg::TLMS_SUPV && wr_val > tlms_pkg::TOP_SUPV_DEPTH
        |=> depth_r == tlms_pkg::TOP_SUPV_DEPTH) else $error("supv sat"); // RQ15
    chk_hyper_sat: assert property (@(posedge core_clk) disable iff (sys_rst)
        wr_depth && mode_nxt == tlms_pkg::TLMS_HYPER
        |=> depth_r == (($past(wr_val) > tlms_pkg::TOP_TRAP_DEPTH) ? tlms_pkg::TOP_TRAP_DEPTH
                        : $past(wr_val))) else $error("hyper sat"); // RQ14
    chk_user_fault: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_reg_write_op && !hypervisor_flag && !supervisor_flag
        |=> priv_opcode_fault && $stable(depth_r)) else $error("user write"); // RQ14
    chk_hyper_mode: assert property (@(posedge core_clk) disable iff (sys_rst)
        hypervisor_flag |=> exec_mode == tlms_pkg::TLMS_HYPER) else $error("mode"); // RQ8
    chk_irq_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
        irq_take |-> $past(irq_level) > $past(thresh_r)) else $error("irq gate"); // RQ19
    chk_mask_fetch: assert property (@(posedge core_clk) disable iff (sys_rst)
        mask_rise && !trap_return |=> next_cnt_r[63:32] == tlms_pkg::ZERO_HALF)
        else $error("mask fetch"); // RQ5
    chk_step_keep: assert property (@(posedge core_clk) disable iff (sys_rst)
        retire && !taken_transfer && !trap_return && !mask_rise
        |=> next_cnt_r == $past(next_cnt_r) + tlms_pkg::FETCH_STEP) else $error("step"); // RQ3
    chk_priv_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
        priv_disrupt_take |-> $past(interrupt_enable_bit)) else $error("priv gate"); // RQ9
endmodule

// ==== hw/tlms_pkg.sv ====
// constants for the trap-level and mode-state block
package tlms_pkg;
    localparam int unsigned ADDR_W        = 64;
    localparam int unsigned HALF_W        = 32;
    localparam int unsigned DEPTH_W       = 3;
    localparam int unsigned LEVEL_W       = 4;
    localparam logic [4:0]  REG_TRAP_DEPTH = 5'h07;
    localparam logic [4:0]  REG_THRESHOLD  = 5'h08;
    localparam logic [4:0]  REG_SAVED_CNT  = 5'h00;
    localparam logic [4:0]  REG_SAVED_NEXT = 5'h01;
    localparam logic [2:0]  TOP_TRAP_DEPTH = 3'h6; // RQ12
    localparam logic [2:0]  TOP_SUPV_DEPTH = 3'h2; // RQ12
    localparam logic [3:0]  THRESH_RST     = 4'h0;
    localparam logic [63:0] FETCH_STEP     = 64'h0000_0000_0000_0004;
    localparam logic [31:0] ZERO_HALF      = 32'h0000_0000;
    localparam logic [2:0]  DEPTH_ZERO     = 3'h0;
    localparam logic [2:0]  DEPTH_ONE      = 3'h1;
    localparam bit          RETURN_MASKS   = 1'b1;
    typedef enum logic [2:0]
    {
        TLMS_USER  = 3'b001,
        TLMS_SUPV  = 3'b010,
        TLMS_HYPER = 3'b100
    } tlms_mode_t;
endpackage

// ==== tb/tlms_core_tb.sv ====
// self-checking bench for the trap-level and mode-state block
`timescale 1ns/1ns
module tlms_core_tb;
    typedef struct {logic sup; logic hyp; logic [63:0] wd; logic [2:0] dep;} tlms_row_t;
    logic        core_clk = 0, sys_rst = 1, supervisor_flag = 0, hypervisor_flag = 0;
    logic        address_mask_bit = 0, interrupt_enable_bit = 0, mask_write = 0;
    logic        mask_write_val = 0, state_reg_write_op = 0, state_reg_read_op = 0;
    logic        retire = 0, taken_transfer = 0, trap_entry = 0, trap_return = 0;
    logic        saved_mask = 0, access_fault = 0, priv_disrupt = 0, hyper_disrupt = 0;
    logic        irq_valid = 0;
    logic [4:0]  state_reg_sel = 0;
    logic [3:0]  irq_level = 0, interrupt_threshold, irq_take_level;
    logic [2:0]  saved_depth = 0, trap_depth, exec_mode;
    logic [63:0] state_reg_wdata = 0, transfer_target = 0, saved_counter = 0;
    logic [63:0] saved_next_counter = 0, access_addr = 0, virt_addr = 0;
    logic [63:0] state_reg_rdata, program_counter, next_fetch_counter;
    logic [63:0] data_fault_addr_reg, masked_vaddr;
    logic        in_trap, priv_opcode_fault, priv_disrupt_take, hyper_disrupt_take, irq_take;
    int          fails = 0, comparisons = 0;
    tlms_row_t   rows [9] = '{'{1, 0, 0, 0}, '{1, 0, 2, 2}, '{1, 0, 3, 2}, '{1, 0, 7, 2},
        '{0, 1, 5, 5}, '{0, 1, 7, 6}, '{0, 1, 64'hFFFF_FFFF_FFFF_FFF9, 1}, '{0, 1, 6, 6},
        '{1, 1, 7, 6}};

    tlms_core u_dut (.core_clk, .sys_rst, .supervisor_flag, .hypervisor_flag,
        .address_mask_bit, .interrupt_enable_bit, .mask_write, .mask_write_val,
        .state_reg_write_op, .state_reg_read_op, .state_reg_sel, .state_reg_wdata, .retire,
        .taken_transfer, .transfer_target, .trap_entry, .trap_return, .saved_depth,
        .saved_mask, .saved_counter, .saved_next_counter, .access_fault, .access_addr,
        .virt_addr, .priv_disrupt, .hyper_disrupt, .irq_valid, .irq_level, .trap_depth,
        .interrupt_threshold, .exec_mode, .in_trap, .priv_opcode_fault, .state_reg_rdata,
        .program_counter, .next_fetch_counter, .data_fault_addr_reg, .masked_vaddr,
        .priv_disrupt_take, .hyper_disrupt_take, .irq_take, .irq_take_level);

    always #10 core_clk = ~core_clk;

    task step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task access(input logic wr, input logic [4:0] sel, input logic [63:0] d);
        state_reg_sel = sel;
        state_reg_wdata = d;
        state_reg_write_op = wr;
        state_reg_read_op = !wr;
        step(1);
        state_reg_write_op = 0;
        state_reg_read_op = 0;
    endtask
    task mode(input logic s, input logic h);
        supervisor_flag = s;
        hypervisor_flag = h;
    endtask
    task finish_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk_reset;
        chk("depth", trap_depth, tlms_pkg::TOP_TRAP_DEPTH);
        chk("threshold", interrupt_threshold, 0);
        chk("mode", exec_mode, 3'b001);
        chk("in_trap", in_trap, 1);
        chk("prog cnt", program_counter, 0);
        chk("next cnt", next_fetch_counter, 4);
    endtask

    initial
    begin
        step(5);
        sys_rst = 0;
        chk_reset();
        foreach (rows[i])
        begin
            mode(rows[i].sup, rows[i].hyp);
            access(1, 5'h07, rows[i].wd);
            chk("depth", trap_depth, rows[i].dep);
            chk("fault", priv_opcode_fault, 0);
            chk("mode", exec_mode, rows[i].hyp ? 3'b100 : rows[i].sup ? 3'b010 : 3'b001);
        end
        step(1);
        chk("in_trap", in_trap, 1);
        access(1, 5'h07, 0);
        step(1);
        chk("in_trap", in_trap, 0);
        mode(0, 0);
        step(1);
        access(1, 5'h07, 1);
        chk("user write fault", priv_opcode_fault, 1);
        chk("depth", trap_depth, 0);
        step(1);
        chk("fault pulse", priv_opcode_fault, 0);
        mode(0, 1);
        access(1, 5'h07, 3);
        chk("depth", trap_depth, 3);
        trap_entry = 1;
        step(1);
        trap_entry = 0;
        chk("entry", trap_depth, 4);
        saved_depth = 1;
        trap_return = 1;
        step(1);
        trap_return = 0;
        chk("return", trap_depth, 1);
        priv_disrupt = 1;
        hyper_disrupt = 1;
        for (int i = 0; i < 8; i++)
        begin
            mode(i[0], i[1]);
            interrupt_enable_bit = i[2];
            step(2);
            chk("priv take", priv_disrupt_take, !i[1] && i[2]);
            chk("hyper take", hyper_disrupt_take, !i[1] || i[2]);
        end
        mode(1, 0);
        access(1, 5'h08, 5);
        chk("threshold", interrupt_threshold, 5);
        irq_valid = 1;
        for (int l = 4; l < 7; l++)
        begin
            irq_level = l[3:0];
            step(1);
            chk("irq take", irq_take, l > 5);
        end
        chk("irq level", irq_take_level, 6);
        access(1, 5'h08, 15);
        irq_level = 15;
        step(2);
        chk("irq 15 masked", irq_take, 0);
        access(1, 5'h08, 14);
        step(1);
        chk("irq 15 taken", irq_take, 1);
        irq_valid = 0;
        address_mask_bit = 1;
        virt_addr = 64'h1234_5678_9ABC_DEF0;
        access_addr = virt_addr;
        access_fault = 1;
        step(1);
        access_fault = 0;
        chk("masked va", masked_vaddr, 64'h0000_0000_9ABC_DEF0);
        chk("fault addr", data_fault_addr_reg, 64'h0000_0000_9ABC_DEF0);
        transfer_target = 64'hAAAA_0000_0000_1000;
        retire = 1;
        taken_transfer = 1;
        step(1);
        taken_transfer = 0;
        chk("next cnt target", next_fetch_counter, transfer_target);
        step(1);
        retire = 0;
        chk("next cnt step", next_fetch_counter, transfer_target + 64'h4);
        chk("prog cnt follow", program_counter, transfer_target);
        saved_counter = 64'hBBBB_CCCC_0000_0010;
        saved_next_counter = 64'hDDDD_EEEE_0000_0014;
        access(0, 5'h00, 0);
        chk("saved cnt read", state_reg_rdata, saved_counter);
        access(0, 5'h01, 0);
        chk("saved next read", state_reg_rdata, saved_next_counter);
        address_mask_bit = 0;
        mask_write = 1;
        mask_write_val = 1;
        step(1);
        mask_write = 0;
        address_mask_bit = 1;
        chk("next cnt upper", next_fetch_counter[63:32], 0);
        saved_mask = 1;
        trap_return = 1;
        step(1);
        trap_return = 0;
        saved_mask = 0;
        chk("ret prog cnt", program_counter, 64'h0000_0000_0000_0010);
        chk("ret next cnt", next_fetch_counter, 64'h0000_0000_0000_0014);
        sys_rst = 1;
        step(1);
        sys_rst = 0;
        chk_reset();
        finish_test();
    end

    initial
    begin
        step(2000);
        fails++;
        finish_test();
    end
endmodule
